//--- verilog/ipv_irq_priority_vector_regs.sv
`timescale 1ns/1ps
`include "ipv_params.svh"

// Contract
// - priority A: 16 bits, zero reset, standby holds
// - power-on and manual reset both clear
// - A[15:12] is divider interrupt level
// - A[11:8] shared level for both DMA
// - DMA channel 0 beats channel 1
// - A[7:4] shared watchdog and refresh level
// - watchdog interval beats refresh match
// - reserved bits read zero, write zero
// - priority B: 16 bits, zero reset, holds
// - B[15:12] is serial interrupt level
// - B[11:8] is free-running timer level
// - levels unsigned, zero lowest, fifteen highest
// - shared field gives identical level
// - vector register: 16 bits, zero reset, holds
// - V[14:8] is interval vector number
// - V[6:0] is refresh match vector
// - table address is base plus four times vector
module ipv_irq_priority_vector_regs
  import ipv_pkg::*;
#(
  parameter int AW = 8,
  parameter int DW = 32
) (
  input  wire logic          CLK,
  input  wire logic          RESET_N,
  input  wire logic          MANUAL_RESET_N,
  // avalon-mm slave
  input  wire logic [AW-1:0] AVS_ADDRESS,
  input  wire logic          AVS_READ,
  input  wire logic          AVS_WRITE,
  input  wire logic [DW-1:0] AVS_WRITEDATA,
  input  wire logic [3:0]    AVS_BYTEENABLE,
  output logic      [DW-1:0] AVS_READDATA,
  output logic               AVS_WAITREQUEST,
  // pending peripheral requests
  input  wire logic          DIVIDER_IRQ,
  input  wire logic          DMA0_IRQ,
  input  wire logic          DMA1_IRQ,
  input  wire logic          INTERVAL_IRQ,
  input  wire logic          REFRESH_MATCH_IRQ,
  input  wire logic          SERIAL_IRQ,
  input  wire logic          FREERUN_TIMER_IRQ,
  // field outputs towards arbitration and core
  output ipv_level_t         DIVIDER_IRQ_LEVEL,
  output ipv_level_t         DMA_IRQ_LEVEL,
  output ipv_level_t         WATCHDOG_IRQ_LEVEL,
  output ipv_level_t         SERIAL_IRQ_LEVEL,
  output ipv_level_t         FREERUN_TIMER_IRQ_LEVEL,
  output ipv_vector_t        INTERVAL_IRQ_VECTOR,
  output ipv_vector_t        REFRESH_MATCH_IRQ_VECTOR,
  // arbitration result, registered
  output logic               IRQ_REQUEST,
  output ipv_level_t         IRQ_LEVEL,
  output logic [6:0]         IRQ_SOURCE,
  output logic               IRQ_VECTOR_VALID,
  output logic [31:0]        IRQ_VECTOR_ADDR
);

  localparam int NS = `IPV_N_SRC;   // number of sources
  localparam int LW = `IPV_LVL_W;   // level width

  // combined reset
  logic           rst_n;
  // bus handshake
  ipv_bus_state_t state;            // handshake phase
  ipv_bus_state_t next_state;       // phase after this edge
  logic           req;              // master is asking
  logic           wr_go;            // write takes effect now
  // address decode
  logic           hit_a;
  logic           hit_b;
  logic           hit_v;
  logic           hit_base;
  logic           hit_stat;
  // lane enables
  logic [15:0]    ben16;            // 16-bit registers
  logic [31:0]    ben32;            // vector base
  // register contents
  logic [15:0]    prio_a;           // priority_levels_a
  logic [15:0]    prio_b;           // priority_levels_b
  logic [15:0]    wdt_vec;          // watchdog_refresh_vectors
  logic [31:0]    vec_base;         // vector_base_register
  // read path
  logic [31:0]    rd_mux;
  logic [15:0]    status;
  // arbitration
  logic [NS*LW-1:0] lvl_vec;
  logic [NS-1:0]    req_vec;
  logic [NS-1:0]    grant;
  ipv_level_t       win_lvl;
  logic             win_any;
  ipv_vector_t      win_vec;
  logic             win_has_vec;

  // either reset source clears the whole block
  assign rst_n = RESET_N & MANUAL_RESET_N;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------

  // read and write never high together, per the bus rules
  assign req = AVS_READ | AVS_WRITE;

  // full byte address compare; misaligned hits nothing
  assign hit_a    = (AVS_ADDRESS == `IPV_OFS_PRIO_A);
  assign hit_b    = (AVS_ADDRESS == `IPV_OFS_PRIO_B);
  assign hit_v    = (AVS_ADDRESS == `IPV_OFS_WDT_VEC);
  assign hit_base = (AVS_ADDRESS == `IPV_OFS_VEC_BASE);
  assign hit_stat = (AVS_ADDRESS == `IPV_OFS_STATUS);

  // byte enables widened to bit enables
  assign ben16 = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign ben32 = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                  {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  // write lands on the edge that sees waitrequest low
  assign wr_go = (state == ST_ACK) && AVS_WRITE;

  // next handshake phase
  always_comb begin
    case (state)
      ST_IDLE: begin
        // one wait cycle: keeps read data a clean flop output
        next_state = req ? ST_ACK : ST_IDLE;
      end
      ST_ACK: begin
        // master releases after this edge
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // handshake state
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // waitrequest high except in the answer cycle
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= (next_state != ST_ACK);
    end
  end

  // read mux; narrow registers sit in the low half
  always_comb begin
    case (1'b1)
      hit_a:    rd_mux = {16'h0000, prio_a};
      hit_b:    rd_mux = {16'h0000, prio_b};
      hit_v:    rd_mux = {16'h0000, wdt_vec};
      hit_base: rd_mux = vec_base;
      hit_stat: rd_mux = {16'h0000, status};
      // unmapped address reads zero
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured as the answer cycle begins
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (state == ST_IDLE && AVS_READ) begin
      AVS_READDATA <= rd_mux;
    end else if (state == ST_ACK) begin
      // cleared so stale data never lingers
      AVS_READDATA <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------

  // priority_levels_a: reserved low nibble never stored
  ipv_reg #(
    .W    (16),
    .WMSK (`IPV_WMASK_PRIO_A),
    .RST  (`IPV_RST_PRIO_A)
  ) u_prio_a (
    .clk     (CLK),
    .rst_n   (rst_n),
    .wr_en   (wr_go && hit_a),
    .bit_en  (ben16),
    .wr_data (AVS_WRITEDATA[15:0]),
    .q       (prio_a)
  );

  // priority_levels_b: low byte reserved
  ipv_reg #(
    .W    (16),
    .WMSK (`IPV_WMASK_PRIO_B),
    .RST  (`IPV_RST_PRIO_B)
  ) u_prio_b (
    .clk     (CLK),
    .rst_n   (rst_n),
    .wr_en   (wr_go && hit_b),
    .bit_en  (ben16),
    .wr_data (AVS_WRITEDATA[15:0]),
    .q       (prio_b)
  );

  // watchdog_refresh_vectors: bits 15 and 7 reserved
  ipv_reg #(
    .W    (16),
    .WMSK (`IPV_WMASK_WDT_VEC),
    .RST  (`IPV_RST_WDT_VEC)
  ) u_wdt_vec (
    .clk     (CLK),
    .rst_n   (rst_n),
    .wr_en   (wr_go && hit_v),
    .bit_en  (ben16),
    .wr_data (AVS_WRITEDATA[15:0]),
    .q       (wdt_vec)
  );

  // vector_base_register, full word
  ipv_reg #(
    .W    (32),
    .WMSK (`IPV_WMASK_VEC_BASE),
    .RST  (`IPV_RST_VEC_BASE)
  ) u_vec_base (
    .clk     (CLK),
    .rst_n   (rst_n),
    .wr_en   (wr_go && hit_base),
    .bit_en  (ben32),
    .wr_data (AVS_WRITEDATA),
    .q       (vec_base)
  );

  // ---------------------------------------------------------------
  // field outputs, straight from the register flops
  // ---------------------------------------------------------------

  assign DIVIDER_IRQ_LEVEL  = prio_a[`IPV_DIV_LSB +: LW];
  assign DMA_IRQ_LEVEL      = prio_a[`IPV_DMA_LSB +: LW];
  assign WATCHDOG_IRQ_LEVEL = prio_a[`IPV_WDT_LSB +: LW];
  assign SERIAL_IRQ_LEVEL   = prio_b[`IPV_SER_LSB +: LW];
  assign FREERUN_TIMER_IRQ_LEVEL =
    prio_b[`IPV_FRT_LSB +: LW];
  assign INTERVAL_IRQ_VECTOR =
    wdt_vec[`IPV_ITV_LSB +: `IPV_VEC_W];
  assign REFRESH_MATCH_IRQ_VECTOR =
    wdt_vec[`IPV_RMV_LSB +: `IPV_VEC_W];

  // ---------------------------------------------------------------
  // arbitration among peripheral requests
  // ---------------------------------------------------------------

  // shared fields feed both of their sources alike
  always_comb begin
    lvl_vec = '0;
    lvl_vec[`IPV_SRC_DIV*LW  +: LW] = DIVIDER_IRQ_LEVEL;
    lvl_vec[`IPV_SRC_DMA0*LW +: LW] = DMA_IRQ_LEVEL;
    lvl_vec[`IPV_SRC_DMA1*LW +: LW] = DMA_IRQ_LEVEL;
    lvl_vec[`IPV_SRC_ITI*LW  +: LW] = WATCHDOG_IRQ_LEVEL;
    lvl_vec[`IPV_SRC_CMI*LW  +: LW] = WATCHDOG_IRQ_LEVEL;
    lvl_vec[`IPV_SRC_SER*LW  +: LW] = SERIAL_IRQ_LEVEL;
    lvl_vec[`IPV_SRC_FRT*LW  +: LW] = FREERUN_TIMER_IRQ_LEVEL;
  end

  // index order sets the tie break among equal levels
  always_comb begin
    req_vec = '0;
    req_vec[`IPV_SRC_DIV]  = DIVIDER_IRQ;
    req_vec[`IPV_SRC_DMA0] = DMA0_IRQ;
    req_vec[`IPV_SRC_DMA1] = DMA1_IRQ;
    req_vec[`IPV_SRC_ITI]  = INTERVAL_IRQ;
    req_vec[`IPV_SRC_CMI]  = REFRESH_MATCH_IRQ;
    req_vec[`IPV_SRC_SER]  = SERIAL_IRQ;
    req_vec[`IPV_SRC_FRT]  = FREERUN_TIMER_IRQ;
  end

  // unsigned compare, zero lowest, fifteen highest
  ipv_arbiter #(
    .N  (NS),
    .LW (LW)
  ) u_arb (
    .levels (lvl_vec),
    .req    (req_vec),
    .grant  (grant),
    .level  (win_lvl),
    .any    (win_any)
  );

  // only the two sources of this block carry a vector here
  always_comb begin
    win_has_vec = 1'b0;
    win_vec     = '0;
    if (grant[`IPV_SRC_ITI]) begin
      win_has_vec = 1'b1;
      win_vec     = INTERVAL_IRQ_VECTOR;
    end else if (grant[`IPV_SRC_CMI]) begin
      win_has_vec = 1'b1;
      win_vec     = REFRESH_MATCH_IRQ_VECTOR;
    end
  end

  // winner registered; one cycle behind the request lines
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      IRQ_REQUEST <= 1'b0;
      IRQ_LEVEL   <= '0;
      IRQ_SOURCE  <= '0;
    end else begin
      IRQ_REQUEST <= win_any;
      IRQ_LEVEL   <= win_lvl;
      IRQ_SOURCE  <= grant;
    end
  end

  // table entry address for the winning vector
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      IRQ_VECTOR_VALID <= 1'b0;
      IRQ_VECTOR_ADDR  <= 32'h0000_0000;
    end else if (win_has_vec) begin
      IRQ_VECTOR_VALID <= 1'b1;
      IRQ_VECTOR_ADDR  <= vec_base + {23'h000000, win_vec, 2'b00};
    end else begin
      // other sources take their vector elsewhere
      IRQ_VECTOR_VALID <= 1'b0;
      IRQ_VECTOR_ADDR  <= 32'h0000_0000;
    end
  end

  // status word shows the registered winner
  always_comb begin
    status = 16'h0000;
    status[`IPV_ST_SRC_LSB +: 7] = IRQ_SOURCE;
    status[`IPV_ST_LVL_LSB +: LW] = IRQ_LEVEL;
    status[`IPV_ST_PEND_BIT] = IRQ_REQUEST;
  end

endmodule

//--- verilog/ipv_params.svh
`ifndef IPV_PARAMS_SVH
`define IPV_PARAMS_SVH

// register byte offsets on the slave port
`define IPV_OFS_PRIO_A     8'h00
`define IPV_OFS_PRIO_B     8'h04
`define IPV_OFS_WDT_VEC    8'h08
`define IPV_OFS_VEC_BASE   8'h0C
`define IPV_OFS_STATUS     8'h10

// reset values
`define IPV_RST_PRIO_A     16'h0000
`define IPV_RST_PRIO_B     16'h0000
`define IPV_RST_WDT_VEC    16'h0000
`define IPV_RST_VEC_BASE   32'h0000_0000

// writable bits; the rest are reserved and read zero
`define IPV_WMASK_PRIO_A   16'hFFF0
`define IPV_WMASK_PRIO_B   16'hFF00
`define IPV_WMASK_WDT_VEC  16'h7F7F
`define IPV_WMASK_VEC_BASE 32'hFFFF_FFFF

// field positions (lsb) and widths
`define IPV_LVL_W          4
`define IPV_VEC_W          7
`define IPV_DIV_LSB        12
`define IPV_DMA_LSB        8
`define IPV_WDT_LSB        4
`define IPV_SER_LSB        12
`define IPV_FRT_LSB        8
`define IPV_ITV_LSB        8
`define IPV_RMV_LSB        0

// status register fields
`define IPV_ST_SRC_LSB     0
`define IPV_ST_LVL_LSB     8
`define IPV_ST_PEND_BIT    15

// source indexes, index 0 wins ties
`define IPV_SRC_DIV        0
`define IPV_SRC_DMA0       1
`define IPV_SRC_DMA1       2
`define IPV_SRC_ITI        3
`define IPV_SRC_CMI        4
`define IPV_SRC_SER        5
`define IPV_SRC_FRT        6
`define IPV_N_SRC          7

`endif

//--- verilog/ipv_pkg.sv
package ipv_pkg;
  // bus handshake states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } ipv_bus_state_t;

  // priority level and vector number
  typedef logic [3:0] ipv_level_t;
  typedef logic [6:0] ipv_vector_t;
endpackage

//--- verilog/ipv_reg.sv
`timescale 1ns/1ps
// one software register; only writable bits ever hold a one
module ipv_reg
  import ipv_pkg::*;
#(
  parameter int           W    = 16,
  parameter logic [W-1:0] WMSK = '1,
  parameter logic [W-1:0] RST  = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] bit_en,
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] q
);

  logic [W-1:0] wbits; // lanes that this write may touch

  // reserved bits never open to a write
  assign wbits = bit_en & WMSK;

  // sync reset; no standby input, so contents hold through it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= RST;
    end else if (wr_en) begin
      q <= (q & ~wbits) | (wr_data & wbits);
    end
  end

endmodule

//--- verilog/ipv_arbiter.sv
`timescale 1ns/1ps
// highest level wins; equal levels go to the lowest index
module ipv_arbiter
  import ipv_pkg::*;
#(
  parameter int N  = 7,
  parameter int LW = 4
) (
  input  wire logic [N*LW-1:0] levels,
  input  wire logic [N-1:0]    req,
  output logic      [N-1:0]    grant,
  output logic      [LW-1:0]   level,
  output logic                 any
);

  // walk sources in default order; strict compare keeps the tie
  always_comb begin
    logic [LW-1:0] best;
    logic [N-1:0]  pick;
    logic          hit;
    best = '0;
    pick = '0;
    hit  = 1'b0;
    for (int i = 0; i < N; i++) begin
      // level zero can never be taken
      if (req[i] && (levels[i*LW +: LW] > best)) begin
        best = levels[i*LW +: LW];
        pick = '0;
        pick[i] = 1'b1;
        hit = 1'b1;
      end
    end
    grant = pick;
    level = best;
    any   = hit;
  end

endmodule

//--- sim/ipv_irq_sources.sv
`timescale 1ns/1ps
// peripheral request lines as the far side raises them
module ipv_irq_sources
  import ipv_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [6:0] pattern,
  output logic      [6:0] irq_out
);
  // sources change only just after an edge, like real peripherals
  // order: div, dma0, dma1, interval, match, serial, timer
  always_ff @(posedge clk) begin
    irq_out <= pattern;
  end
endmodule

//--- sim/ipv_irq_priority_vector_regs_assertions.sv
`timescale 1ns/1ps
`include "ipv_params.svh"
// watches only the top-level ports of the register block
module ipv_irq_priority_vector_regs_chk
  import ipv_pkg::*;
#(
  parameter int AW = 8,
  parameter int DW = 32
) (
  input wire logic          CLK,
  input wire logic          RESET_N,
  input wire logic          MANUAL_RESET_N,
  input wire logic [AW-1:0] AVS_ADDRESS,
  input wire logic          AVS_READ,
  input wire logic          AVS_WRITE,
  input wire logic [DW-1:0] AVS_WRITEDATA,
  input wire logic [3:0]    AVS_BYTEENABLE,
  input wire logic [DW-1:0] AVS_READDATA,
  input wire logic          AVS_WAITREQUEST,
  input wire logic          DMA0_IRQ,
  input wire logic          DMA1_IRQ,
  input wire logic          INTERVAL_IRQ,
  input wire logic          REFRESH_MATCH_IRQ,
  input wire ipv_level_t    DIVIDER_IRQ_LEVEL,
  input wire ipv_level_t    DMA_IRQ_LEVEL,
  input wire ipv_level_t    WATCHDOG_IRQ_LEVEL,
  input wire ipv_level_t    SERIAL_IRQ_LEVEL,
  input wire logic          IRQ_REQUEST,
  input wire ipv_level_t    IRQ_LEVEL,
  input wire logic [6:0]    IRQ_SOURCE,
  input wire logic          IRQ_VECTOR_VALID
);
  logic       rst;    // either reset source
  logic [3:0] wr_div; // divider field of the write word
  assign rst    = !RESET_N || !MANUAL_RESET_N;
  assign wr_div = AVS_WRITEDATA[15:12];

  // completed write to the first priority register, top lane on
  sequence s_wr_a;
    AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[1]
      && AVS_ADDRESS == `IPV_OFS_PRIO_A;
  endsequence
  // answer cycle of a read of the second priority register
  sequence s_rd_b;
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `IPV_OFS_PRIO_B;
  endsequence

  property p_rst_manual;
    @(posedge CLK) disable iff (!RESET_N)
    !MANUAL_RESET_N |=> DIVIDER_IRQ_LEVEL == 4'h0
      && SERIAL_IRQ_LEVEL == 4'h0 && !IRQ_REQUEST && AVS_WAITREQUEST;
  endproperty
  a_rst_manual: assert property (p_rst_manual)
    else $error("manual reset left state behind");
  property p_wr_div;
    @(posedge CLK) disable iff (rst)
    s_wr_a |=> DIVIDER_IRQ_LEVEL == $past(wr_div);
  endproperty
  a_wr_div: assert property (p_wr_div)
    else $error("divider level not taken from bits 15..12");
  property p_dma_order;
    @(posedge CLK) disable iff (rst)
    DMA0_IRQ && DMA1_IRQ |=> !IRQ_SOURCE[2];
  endproperty
  a_dma_order: assert property (p_dma_order)
    else $error("second dma channel beat the first");
  property p_wdt_order;
    @(posedge CLK) disable iff (rst)
    INTERVAL_IRQ && REFRESH_MATCH_IRQ |=> !IRQ_SOURCE[4];
  endproperty
  a_wdt_order: assert property (p_wdt_order)
    else $error("refresh match beat interval interrupt");
  property p_dma_share;
    @(posedge CLK) disable iff (rst)
    IRQ_SOURCE[2] |-> IRQ_LEVEL == $past(DMA_IRQ_LEVEL);
  endproperty
  a_dma_share: assert property (p_dma_share)
    else $error("dma channel 1 level differs from shared field");
  property p_match_share;
    @(posedge CLK) disable iff (rst)
    IRQ_SOURCE[4] |-> IRQ_LEVEL == $past(WATCHDOG_IRQ_LEVEL);
  endproperty
  a_match_share: assert property (p_match_share)
    else $error("refresh match level differs from shared field");
  property p_lvl_zero;
    @(posedge CLK) disable iff (rst)
    IRQ_SOURCE != 7'h00 |-> IRQ_LEVEL != 4'h0 && IRQ_REQUEST;
  endproperty
  a_lvl_zero: assert property (p_lvl_zero)
    else $error("a level zero source won");
  property p_resv_b;
    @(posedge CLK) disable iff (rst)
    s_rd_b |-> AVS_READDATA[7:0] == 8'h00 && AVS_READDATA[31:16] == 16'h0;
  endproperty
  a_resv_b: assert property (p_resv_b)
    else $error("reserved bits of second priority register not zero");
  property p_itv_valid;
    @(posedge CLK) disable iff (rst)
    IRQ_SOURCE[3] || IRQ_SOURCE[4] |-> IRQ_VECTOR_VALID;
  endproperty
  a_itv_valid: assert property (p_itv_valid)
    else $error("vector not flagged for watchdog group winner");
endmodule

bind ipv_irq_priority_vector_regs ipv_irq_priority_vector_regs_chk #(
  .AW(AW), .DW(DW)
) chk (
  .CLK(CLK), .RESET_N(RESET_N), .MANUAL_RESET_N(MANUAL_RESET_N),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .DMA0_IRQ(DMA0_IRQ), .DMA1_IRQ(DMA1_IRQ), .INTERVAL_IRQ(INTERVAL_IRQ),
  .REFRESH_MATCH_IRQ(REFRESH_MATCH_IRQ),
  .DIVIDER_IRQ_LEVEL(DIVIDER_IRQ_LEVEL), .DMA_IRQ_LEVEL(DMA_IRQ_LEVEL),
  .WATCHDOG_IRQ_LEVEL(WATCHDOG_IRQ_LEVEL),
  .SERIAL_IRQ_LEVEL(SERIAL_IRQ_LEVEL), .IRQ_REQUEST(IRQ_REQUEST),
  .IRQ_LEVEL(IRQ_LEVEL), .IRQ_SOURCE(IRQ_SOURCE),
  .IRQ_VECTOR_VALID(IRQ_VECTOR_VALID)
);

//--- sim/test_irq_priority_vector_regs.sv
`timescale 1ns/1ps
module test_irq_priority_vector_regs
  import ipv_pkg::*;
  ;
  logic        CLK = 1'b0;   // 100 MHz
  logic        RESET_N = 1'b0;
  logic        MANUAL_RESET_N = 1'b1;
  logic [7:0]  adr;          // bus request signals
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [3:0]  be;           // byte lanes of the request
  logic [31:0] rdat;
  logic        wait_rq;
  logic [6:0]  pat;          // pattern for the source model
  logic [6:0]  irq;
  ipv_level_t  lv_div, lv_dma, lv_wdt, lv_ser, lv_frt, irq_lvl;
  ipv_vector_t vec_itv, vec_rm;
  logic        irq_req, vec_ok;
  logic [6:0]  irq_src;
  logic [31:0] vec_adr, q;
  int          num_errors = 0;
  int          compares = 0;
  // arbitration table: pending, winner, level, table address
  logic [6:0]  pend [7] = '{7'h18, 7'h10, 7'h06, 7'h04, 7'h41, 7'h40, 7'h7F};
  logic [6:0]  win  [7] = '{7'h08, 7'h10, 7'h02, 7'h04, 7'h01, 7'h40, 7'h20};
  logic [3:0]  wlv  [7] = '{4'h2, 4'h2, 4'h5, 4'h5, 4'h3, 4'h1, 4'h7};
  logic [31:0] wad  [7] = '{32'h10A8, 32'h1054, 32'h0, 32'h0, 32'h0,
                            32'h0, 32'h0};

  always #5 CLK = ~CLK;

  ipv_irq_sources src (.clk(CLK), .pattern(pat), .irq_out(irq));

  ipv_irq_priority_vector_regs dut (
    .CLK(CLK), .RESET_N(RESET_N), .MANUAL_RESET_N(MANUAL_RESET_N),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wait_rq), .DIVIDER_IRQ(irq[0]), .DMA0_IRQ(irq[1]),
    .DMA1_IRQ(irq[2]), .INTERVAL_IRQ(irq[3]), .REFRESH_MATCH_IRQ(irq[4]),
    .SERIAL_IRQ(irq[5]), .FREERUN_TIMER_IRQ(irq[6]),
    .DIVIDER_IRQ_LEVEL(lv_div), .DMA_IRQ_LEVEL(lv_dma),
    .WATCHDOG_IRQ_LEVEL(lv_wdt), .SERIAL_IRQ_LEVEL(lv_ser),
    .FREERUN_TIMER_IRQ_LEVEL(lv_frt), .INTERVAL_IRQ_VECTOR(vec_itv),
    .REFRESH_MATCH_IRQ_VECTOR(vec_rm), .IRQ_REQUEST(irq_req),
    .IRQ_LEVEL(irq_lvl), .IRQ_SOURCE(irq_src),
    .IRQ_VECTOR_VALID(vec_ok), .IRQ_VECTOR_ADDR(vec_adr)
  );

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one access; the request stands until the rising edge that sees
  // waitrequest low, read data is taken at that edge, then released
  task automatic bus(input logic is_rd, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    adr  <= a;
    wdat <= d;
    rd   <= is_rd;
    wr   <= !is_rd;
    do begin
      @(posedge CLK);
      n++;
    end while (wait_rq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      $display("MISMATCH bus_answer expected 0 seen timeout");
      give_verdict();
    end
  endtask

  // let the source model and the arbiter each take one edge
  task automatic raise(input logic [6:0] p);
    @(posedge CLK);
    pat <= p;
    repeat (3) @(posedge CLK);
    @(negedge CLK);
  endtask

  initial begin
    adr = 8'h00; rd = 1'b0; wr = 1'b0; wdat = 32'h0; pat = 7'h00;
    be = 4'hF;
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    // reset values of the three 16-bit registers
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'(4 * i), 32'h0);
      chk("reg_reset", 32'h0, q);
    end
    $display("test reset_values done");
    // reserved bits written as ones must read back zero
    bus(1'b0, 8'h00, 32'hFFFF_352F);
    bus(1'b0, 8'h04, 32'h0000_71FF);
    bus(1'b0, 8'h08, 32'h0000_AA95);
    bus(1'b0, 8'h0C, 32'h0000_1000);
    bus(1'b0, 8'h14, 32'hFFFF_FFFF);
    bus(1'b1, 8'h00, 32'h0); chk("prio_a", 32'h3520, q);
    bus(1'b1, 8'h04, 32'h0); chk("prio_b", 32'h7100, q);
    bus(1'b1, 8'h08, 32'h0); chk("vectors", 32'h2A15, q);
    bus(1'b1, 8'h14, 32'h0); chk("unmapped", 32'h0, q);
    bus(1'b1, 8'h0C, 32'h0); chk("vec_base", 32'h1000, q);
    chk("div_lvl", 32'h3, 32'(lv_div));
    chk("dma_lvl", 32'h5, 32'(lv_dma));
    chk("wdt_lvl", 32'h2, 32'(lv_wdt));
    chk("ser_lvl", 32'h7, 32'(lv_ser));
    chk("frt_lvl", 32'h1, 32'(lv_frt));
    chk("itv_vec", 32'h2A, 32'(vec_itv));
    chk("rm_vec", 32'h15, 32'(vec_rm));
    $display("test field_map done");
    // ties, shared levels, highest level first
    for (int i = 0; i < 7; i++) begin
      raise(pend[i]);
      chk("source", 32'(win[i]), 32'(irq_src));
      chk("vec_valid", 32'(wad[i] != 32'h0), 32'(vec_ok));
      chk("level", 32'(wlv[i]), 32'(irq_lvl));
      chk("vec_addr", wad[i], vec_adr);
    end
    bus(1'b1, 8'h10, 32'h0); chk("status", 32'h8720, q);
    $display("test arbitration done");
    // a zero level masks the shared dma field
    bus(1'b0, 8'h00, 32'h0000_3020);
    raise(7'h06);
    chk("masked", 32'h0, 32'(irq_req));
    $display("test level_zero done");
    // low lane alone: only the watchdog field may change
    @(posedge CLK);
    be <= 4'h1;
    bus(1'b0, 8'h00, 32'h0000_FFF0);
    be <= 4'hF;
    bus(1'b1, 8'h00, 32'h0); chk("byte_lane", 32'h30F0, q);
    $display("test byte_lanes done");
    // manual reset clears as power-on reset does
    @(posedge CLK);
    MANUAL_RESET_N <= 1'b0;
    @(posedge CLK);
    MANUAL_RESET_N <= 1'b1;
    bus(1'b1, 8'h00, 32'h0); chk("man_rst_a", 32'h0, q);
    bus(1'b1, 8'h08, 32'h0); chk("man_rst_v", 32'h0, q);
    chk("man_rst_lvl", 32'h0, 32'(lv_ser));
    $display("test manual_reset done");
    give_verdict();
  end
endmodule
